// file: wcs_cond_det.sv
// Edge and start/stop detector on the sampled serial lines.
`timescale 1ns/10ps
module wcs_cond_det (
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl_i,
    input wire logic sda_i,
    wcs_line_if.det line
);
    logic scl_q;
    logic sda_q;

    // Idle lines are high, so the history starts high to avoid a false edge.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    assign line.scl_rise = scl_i & ~scl_q;
    assign line.scl_fall = ~scl_i & scl_q;
    assign line.start_seen = scl_i & scl_q & sda_q & ~sda_i;
    assign line.stop_seen = scl_i & scl_q & ~sda_q & sda_i;
    assign line.sda_level = sda_i;
endmodule : wcs_cond_det

// file: wcs_line_if.sv
// Line events passed from the bus condition detector to the slave core.
`timescale 1ns/10ps
interface wcs_line_if;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic sda_level;

    modport det (
        output scl_rise,
        output scl_fall,
        output start_seen,
        output stop_seen,
        output sda_level
    );
    modport core (
        input scl_rise,
        input scl_fall,
        input start_seen,
        input stop_seen,
        input sda_level
    );
endinterface : wcs_line_if

// file: wcs_master_model.sv
// Behavioural two-wire bus master for the serial slave.
`timescale 1ns/10ps
module wcs_master_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_rel
);
    logic [7:0] res = 8'h00;
    logic res_v = 1'b0;
    int lo = 4;
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    task start;
        sda_rel = 1'b1;
        wt(lo);
        scl = 1'b1;
        wt(4);
        sda_rel = 1'b0;
        wt(4);
        scl = 1'b0;
        // Keep data still for a while after the clock falls.
        wt(2);
    endtask : start
    // Data is pulled low first so a no-acknowledge still ends cleanly.
    task stop;
        sda_rel = 1'b0;
        wt(lo);
        scl = 1'b1;
        wt(4);
        sda_rel = 1'b1;
        wt(6);
    endtask : stop
    task clk_bit(input logic b, output logic r);
        sda_rel = b;
        wt(lo);
        scl = 1'b1;
        wt(2);
        r = sda_line;
        wt(3);
        scl = 1'b0;
        wt(lo);
    endtask : clk_bit
    // For reads, d[0] is the acknowledge the master gives.
    task xfer(input logic rd, input logic [7:0] d);
        logic [8:0] sh;
        logic [8:0] r;
        sh = rd ? {8'hFF, d[0]} : {d, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            clk_bit(sh[i], r[i]);
        end
        res = rd ? r[8:1] : {7'h00, r[0]};
        res_v = 1'b1;
        #1 res_v = 1'b0;
    endtask : xfer
endmodule : wcs_master_model

// file: wcs_pkg.sv
// Shared constants and types for the wiper-code serial slave.
package wcs_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h2E;
    localparam logic RW_READ = 1'b1;
    localparam logic [6:0] WIPER_RESET = 7'h40;
    localparam int WIPER_W = 7;
    localparam int TAP_COUNT = 128;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam int ADDR_MSB = 7;
    localparam int ADDR_LSB = 1;
    localparam int RW_POS = 0;
    localparam int DATA_MSB = 7;
    localparam logic RD_PAD = 1'b0;
    localparam logic SDA_LOW = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_DATA,
        ST_WR_ACK,
        ST_RD_DATA,
        ST_RD_ACK
    } wcs_state_t;
endpackage : wcs_pkg

// file: wcs_slave.sv
// Two-wire serial slave holding the 7-bit wiper code.
//
// Operation
// - Respond only when the first seven address bits equal the fixed address.
// - Eighth address bit zero means write, one means read.
// - On address match, hold SDA low through the ninth clock pulse.
// - On mismatch, leave SDA released and idle until the next start.
// - Write data byte: top bit ignored, low seven bits become wiper code.
// - Each byte is eight bits MSB first plus one acknowledge pulse.
// - SDA changes only while SCL is low, stable while SCL high.
// - Read byte is a zero bit then seven wiper bits, nine pulses.
// - Read ends on master no-acknowledge; device then releases SDA.
// - Further write bytes each load the wiper code and are acknowledged.
// - Read returns the wiper code again while the master acknowledges.
// - Wiper code sits in a 7-bit latch driving a one-hot tap decoder.
// - Incoming serial data is sampled on the rising SCL edge.
`timescale 1ns/10ps
module wcs_slave (
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic [wcs_pkg::WIPER_W-1:0] wiper_setting_latch,
    output logic [wcs_pkg::TAP_COUNT-1:0] tap_sel
);
    wcs_line_if line ();

    wcs_cond_det u_det (
        .clk(clk),
        .resetn(resetn),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .line(line)
    );

    wcs_pkg::wcs_state_t state_q;
    wcs_pkg::wcs_state_t state_d;
    logic [2:0] bit_q;
    logic [2:0] bit_d;
    logic byte_done_q;
    logic byte_done_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic oe_q;
    logic oe_d;
    logic master_ack_q;
    logic master_ack_d;
    logic [wcs_pkg::WIPER_W-1:0] wiper_q;
    logic [wcs_pkg::WIPER_W-1:0] wiper_d;
    logic sda_o_q;

    // Decoding of the shift register and line events.
    wire [7:0] shift_in = {shift_q[6:0], line.sda_level};
    wire in_byte = (state_q == wcs_pkg::ST_ADDR) ||
                   (state_q == wcs_pkg::ST_WR_DATA) ||
                   (state_q == wcs_pkg::ST_RD_DATA);
    wire last_bit = (bit_q == wcs_pkg::BIT_LAST);
    wire addr_hit = (shift_q[wcs_pkg::ADDR_MSB:wcs_pkg::ADDR_LSB] ==
                     wcs_pkg::DEV_ADDR);
    wire rw_read = (shift_q[wcs_pkg::RW_POS] == wcs_pkg::RW_READ);
    wire wr_byte_done = (state_q == wcs_pkg::ST_WR_DATA) &&
                        line.scl_rise && last_bit;
    wire [7:0] rd_load = {wcs_pkg::RD_PAD, wiper_q};
    // The device pulls low for a zero bit and releases for a one bit.
    wire rd_drive = (shift_q[wcs_pkg::DATA_MSB] == wcs_pkg::SDA_LOW);
    wire rd_first_drive = (rd_load[wcs_pkg::DATA_MSB] == wcs_pkg::SDA_LOW);

    // Wiper loads at the eighth rising edge, so a stop that slips in
    // before the acknowledge still keeps the complete byte.
    assign wiper_d = wr_byte_done ?
                     shift_in[wcs_pkg::WIPER_W-1:0] : wiper_q;

    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        byte_done_d = byte_done_q;
        shift_d = shift_q;
        oe_d = oe_q;
        master_ack_d = master_ack_q;
        if (line.start_seen) begin
            // A start anywhere, even a repeated one, restarts addressing.
            state_d = wcs_pkg::ST_ADDR;
            bit_d = wcs_pkg::BIT_FIRST;
            byte_done_d = 1'b0;
            oe_d = 1'b0;
        end else if (line.stop_seen) begin
            state_d = wcs_pkg::ST_IDLE;
            bit_d = wcs_pkg::BIT_FIRST;
            byte_done_d = 1'b0;
            oe_d = 1'b0;
        end else if (line.scl_rise) begin
            if (in_byte && !byte_done_q) begin
                shift_d = shift_in;
                bit_d = bit_q + 3'h1;
                byte_done_d = last_bit;
            end
            if (state_q == wcs_pkg::ST_RD_ACK) begin
                master_ack_d = (line.sda_level == wcs_pkg::SDA_LOW);
            end
        end else if (line.scl_fall) begin
            // Every drive change happens on a falling edge, SCL low.
            case (state_q)
                wcs_pkg::ST_ADDR: begin
                    if (byte_done_q) begin
                        byte_done_d = 1'b0;
                        if (addr_hit) begin
                            state_d = wcs_pkg::ST_ADDR_ACK;
                            oe_d = 1'b1;
                        end else begin
                            state_d = wcs_pkg::ST_IDLE;
                            oe_d = 1'b0;
                        end
                    end
                end
                wcs_pkg::ST_ADDR_ACK: begin
                    bit_d = wcs_pkg::BIT_FIRST;
                    if (rw_read) begin
                        state_d = wcs_pkg::ST_RD_DATA;
                        shift_d = rd_load;
                        oe_d = rd_first_drive;
                    end else begin
                        state_d = wcs_pkg::ST_WR_DATA;
                        oe_d = 1'b0;
                    end
                end
                wcs_pkg::ST_WR_DATA: begin
                    if (byte_done_q) begin
                        byte_done_d = 1'b0;
                        state_d = wcs_pkg::ST_WR_ACK;
                        oe_d = 1'b1;
                    end
                end
                wcs_pkg::ST_WR_ACK: begin
                    state_d = wcs_pkg::ST_WR_DATA;
                    bit_d = wcs_pkg::BIT_FIRST;
                    oe_d = 1'b0;
                end
                wcs_pkg::ST_RD_DATA: begin
                    if (byte_done_q) begin
                        byte_done_d = 1'b0;
                        state_d = wcs_pkg::ST_RD_ACK;
                        oe_d = 1'b0;
                    end else begin
                        oe_d = rd_drive;
                    end
                end
                wcs_pkg::ST_RD_ACK: begin
                    bit_d = wcs_pkg::BIT_FIRST;
                    if (master_ack_q) begin
                        state_d = wcs_pkg::ST_RD_DATA;
                        shift_d = rd_load;
                        oe_d = rd_first_drive;
                    end else begin
                        // No acknowledge: let go and wait for the stop.
                        state_d = wcs_pkg::ST_IDLE;
                        oe_d = 1'b0;
                    end
                end
                default: begin
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= wcs_pkg::ST_IDLE;
            bit_q <= wcs_pkg::BIT_FIRST;
            byte_done_q <= 1'b0;
            shift_q <= 8'h00;
            oe_q <= 1'b0;
            master_ack_q <= 1'b0;
            wiper_q <= wcs_pkg::WIPER_RESET;
            sda_o_q <= wcs_pkg::SDA_LOW;
        end else begin
            state_q <= state_d;
            bit_q <= bit_d;
            byte_done_q <= byte_done_d;
            shift_q <= shift_d;
            oe_q <= oe_d;
            master_ack_q <= master_ack_d;
            wiper_q <= wiper_d;
            sda_o_q <= wcs_pkg::SDA_LOW;
        end
    end

    // The line is open drain: only a low is ever driven.
    assign sda_o = sda_o_q;
    assign sda_oe = oe_q;
    assign wiper_setting_latch = wiper_q;

    wcs_tap_decoder u_tap (
        .clk(clk),
        .resetn(resetn),
        .code(wiper_q),
        .tap_sel(tap_sel)
    );
endmodule : wcs_slave

// file: wcs_slave_properties.sv
// Port checks for the wiper-code serial slave.
`timescale 1ns/10ps
module wcs_slave_properties (
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic [wcs_pkg::WIPER_W-1:0] wiper_setting_latch,
    input wire logic [wcs_pkg::TAP_COUNT-1:0] tap_sel
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    property p_rst;
        !$past(resetn) |-> !sda_oe &&
            wiper_setting_latch == wcs_pkg::WIPER_RESET;
    endproperty
    property p_oe_up; $rose(sda_oe) |-> !scl_i; endproperty
    property p_oe_dn; $fell(sda_oe) |-> !scl_i; endproperty
    property p_hold; $rose(sda_oe) |-> sda_oe [*4]; endproperty
    property p_pull; sda_oe |-> !sda_o && !sda_i; endproperty
    property p_hi; scl_i && $past(scl_i) |-> $stable(sda_oe); endproperty
    property p_tap;
        $past(resetn) |-> tap_sel == (128'h1 << $past(wiper_setting_latch));
    endproperty
    property p_upd;
        $changed(wiper_setting_latch) |-> scl_i && !sda_oe;
    endproperty
    a_rst: assert property (p_rst)
        else $error("reset state wrong");
    a_oe_up: assert property (p_oe_up)
        else $error("drive began with clock high");
    a_oe_dn: assert property (p_oe_dn)
        else $error("release with clock high");
    a_hold: assert property (p_hold)
        else $error("drive too short");
    a_pull: assert property (p_pull)
        else $error("line not pulled low");
    a_hi: assert property (p_hi)
        else $error("drive moved with clock high");
    a_tap: assert property (p_tap)
        else $error("tap select wrong");
    a_upd: assert property (p_upd)
        else $error("code moved off the rising phase");
    c_upd: cover property ($changed(wiper_setting_latch));
    c_ack: cover property ($fell(sda_oe));
    c_rst: cover property ($rose(resetn));
endmodule : wcs_slave_properties

// file: wcs_slave_tb.sv
// Self-checking bench for the wiper-code serial slave.
`timescale 1ns/10ps
module wcs_slave_tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic scl, sda_rel, sda_o, sda_oe, sda, r;
    logic [wcs_pkg::WIPER_W-1:0] wiper, exp_w;
    logic [wcs_pkg::TAP_COUNT-1:0] tap;
    logic [7:0] exp_q[$];
    logic [7:0] e, d;
    logic [6:0] wa;
    int miscompares = 0;
    int check_count = 0;
    int seed = 8444;
    always #5 clk = ~clk;
    // Pull-up wire: low whenever the device pulls it.
    assign sda = sda_rel & ~(sda_oe & ~sda_o);
    wcs_slave dut_u (.clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .wiper_setting_latch(wiper),
        .tap_sel(tap));
    wcs_master_model m_u (.clk(clk), .sda_line(sda), .scl(scl),
        .sda_rel(sda_rel));
    always @(posedge m_u.res_v) begin
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
        check_count++;
        if (m_u.res !== e) begin
            miscompares++;
            $display("wrong value bus_result exp %h got %h", e, m_u.res);
        end
    end
    task put(input logic [7:0] v, input logic [7:0] x);
        exp_q.push_back(x);
        m_u.xfer(1'b0, v);
    endtask : put
    task get(input logic nack);
        exp_q.push_back({1'b0, exp_w});
        m_u.xfer(1'b1, {7'h00, nack});
    endtask : get
    task rd(input int n);
        put({wcs_pkg::DEV_ADDR, 1'b1}, 8'h00);
        repeat (n) get(1'b0);
        get(1'b1);
        m_u.stop();
    endtask : rd
    // The latch and the one-hot tap select are compared directly.
    task chk_w(input logic [6:0] x);
        check_count++;
        if (wiper !== x || tap !== (128'h1 << x)) begin
            miscompares++;
            $display("wrong value wiper exp %h got %h", x, wiper);
        end
    endtask : chk_w
    task give_verdict;
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        $display("wrong value run_done exp 1 got 0");
        give_verdict();
    end
    initial begin
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        exp_w = wcs_pkg::WIPER_RESET;
        m_u.start();
        rd(1);
        repeat (4) begin
            d = 8'($random(seed));
            m_u.lo = 4 + (d[2:0]);
            m_u.start();
            put({wcs_pkg::DEV_ADDR, 1'b0}, 8'h00);
            put(d, 8'h00);
            chk_w(d[6:0]);
            put(~d, 8'h00);
            chk_w(~d[6:0]);
            exp_w = ~d[6:0];
            m_u.start();
            rd(2);
        end
        m_u.lo = 4;
        for (int k = 0; k < 7; k++) begin
            wa = wcs_pkg::DEV_ADDR ^ (7'h01 << k);
            m_u.start();
            put({wa, 1'b0}, 8'h01);
            put(8'h00, 8'h01);
            m_u.stop();
            chk_w(exp_w);
        end
        m_u.start();
        put({wcs_pkg::DEV_ADDR, 1'b0}, 8'h00);
        repeat (4) m_u.clk_bit(1'b0, r);
        m_u.stop();
        chk_w(exp_w);
        m_u.start();
        rd(0);
        @(negedge clk);
        resetn = 1'b0;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        exp_w = wcs_pkg::WIPER_RESET;
        m_u.start();
        rd(0);
        chk_w(wcs_pkg::WIPER_RESET);
        if (exp_q.size() != 0) begin
            miscompares++;
            $display("wrong value queue_left exp 0 got %0d", exp_q.size());
        end
        give_verdict();
    end
endmodule : wcs_slave_tb
bind wcs_slave wcs_slave_properties chk_u (.clk(clk), .resetn(resetn),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .wiper_setting_latch(wiper_setting_latch), .tap_sel(tap_sel));

// file: wcs_tap_decoder.sv
// One-hot decoder from wiper code to resistor tap select.
`timescale 1ns/10ps
module wcs_tap_decoder (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [wcs_pkg::WIPER_W-1:0] code,
    output logic [wcs_pkg::TAP_COUNT-1:0] tap_sel
);
    logic [wcs_pkg::TAP_COUNT-1:0] tap_d;
    logic [wcs_pkg::TAP_COUNT-1:0] tap_q;

    genvar gi;
    generate
        for (gi = 0; gi < wcs_pkg::TAP_COUNT; gi++) begin : g_tap
            assign tap_d[gi] = (int'(code) == gi);
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!resetn) begin
            // Reset selects the midscale tap so the decoder agrees with the
            // preset latch instead of showing tap zero for a cycle.
            tap_q <= {{(wcs_pkg::TAP_COUNT-1){1'b0}}, 1'b1} <<
                     wcs_pkg::WIPER_RESET;
        end else begin
            tap_q <= tap_d;
        end
    end

    assign tap_sel = tap_q;
endmodule : wcs_tap_decoder
